// [shared/pmat_defs.svh]
`ifndef PMAT_DEFS_SVH
`define PMAT_DEFS_SVH

`define PMAT_XLEN 64
`define PMAT_AW 8

`define PMAT_CNT_OFF 5'h00
`define PMAT_CNT_SV57 5'h07
`define PMAT_CNT_SV48 5'h10
`define PMAT_HI_SV57 64'hfe00_0000_0000_0000
`define PMAT_HI_SV48 64'hffff_0000_0000_0000
`define PMAT_FILL_SV57 56
`define PMAT_FILL_SV48 47

`define PMAT_PMM_OFF 2'h0
`define PMAT_PMM_RSVD 2'h1
`define PMAT_PMM_SV57 2'h2
`define PMAT_PMM_SV48 2'h3

`define PMAT_PRIV_U 2'h0
`define PMAT_PRIV_S 2'h1
`define PMAT_PRIV_M 2'h3

`define PMAT_OFF_PMCFG 8'h00
`define PMAT_OFF_MODE 8'h04
`define PMAT_OFF_TVEC_LO 8'h08
`define PMAT_OFF_TVEC_HI 8'h0c
`define PMAT_OFF_TRIG_LO 8'h10
`define PMAT_OFF_TRIG_HI 8'h14
`define PMAT_OFF_STAT 8'h18
`define PMAT_OFF_TVAL_LO 8'h1c
`define PMAT_OFF_TVAL_HI 8'h20

`define PMAT_NFIELD 6
`define PMAT_CFG_W 12
`define PMAT_F_M 0
`define PMAT_F_S 2
`define PMAT_F_U 4
`define PMAT_F_VS 6
`define PMAT_F_VU 8
`define PMAT_F_HU 10

`define PMAT_MODE_W 10
`define PMAT_B_MODIFY_PRIVILEGE 0
`define PMAT_B_MPP 1
`define PMAT_B_MPV 3
`define PMAT_B_SUPERVISOR_PREV_VIRT_PRIVILEGE 4
`define PMAT_B_MXR 5
`define PMAT_B_VMXR 6
`define PMAT_B_SBARE 7
`define PMAT_B_VSBARE 8
`define PMAT_B_TRIGEN 9

`define PMAT_RST_CFG 12'h000
`define PMAT_RST_MODE 10'h180
`define PMAT_RST_ADDR 64'h0000_0000_0000_0000

`endif

// [shared/pmat_pkg.sv]
`include "pmat_defs.svh"

package pmat_pkg;

	// Access classes; everything up to and including the hypervisor load/store is explicit.
	typedef enum logic [3:0] {
		AK_LOAD,
		AK_STORE,
		AK_AMO,
		AK_FP,
		AK_VEC,
		AK_CBO,
		AK_SSTK,
		AK_HLV,
		AK_HLVX,
		AK_EXT,
		AK_FENCE_INV,
		AK_IMPLICIT,
		AK_DEVICE,
		AK_FETCH
	} pmat_kind_t;

	typedef struct packed {
		logic valid;
		pmat_kind_t kind;
		logic ext_excl;
		logic [1:0] priv;
		logic virt;
		logic [5:0] size_m1;
		logic [`PMAT_XLEN-1:0] addr;
	} pmat_acc_t;

	typedef struct packed {
		logic valid;
		logic masked;
		logic hit;
		logic [`PMAT_XLEN-1:0] addr;
		logic [`PMAT_XLEN-1:0] last_addr;
	} pmat_res_t;

	typedef struct packed {
		logic valid;
		logic has_addr;
		pmat_kind_t kind;
		logic [1:0] priv;
		logic virt;
		logic [`PMAT_XLEN-1:0] addr;
	} pmat_trap_t;

	typedef struct packed {
		logic valid;
		logic [`PMAT_XLEN-1:0] handler;
		logic [`PMAT_XLEN-1:0] tval;
	} pmat_tres_t;

	typedef struct packed {
		logic use_mask;
		logic bare;
		logic [4:0] cnt;
		logic [1:0] priv;
		logic virt;
	} pmat_ctx_t;

endpackage

// [hw/pmat_core.sv]
// The register addresses and the APB interface to the registers were chosen for this implementation.
`include "pmat_defs.svh"

// Operation
// RULE1: Only 16 or 7 masked bits exist; one encoding stays reserved.
// RULE2: Each privilege mode has its own setting, applied for the active mode.
// RULE3: A mode's setting lives in fields owned by the next-higher mode.
// RULE4: Setting selection uses only privilege, never any address bit.
// RULE5: Every explicit data access class is masked.
// RULE6: Explicit accesses of other extensions are masked unless that extension excludes them.
// RULE7: Fence and invalidate operands are never masked.
// RULE8: Modify-privilege and previous-virtual-privilege controls select the effective mode's setting.
// RULE9: Make-executable-readable at the effective mode disables masking, even untranslated.
// RULE10: Cache block operations, including zeroing, use the masked address.
// RULE11: Walks, translation-unit and device accesses are never masked.
// RULE12: Misaligned accesses mask each byte as if separately transformed.
// RULE13: Software register reads and writes store addresses unmasked.
// RULE14: Writable address width of registers is independent of masking.
// RULE15: Hardware-written trap values carry the masked address.
// RULE16: Debug trigger matching compares the masked address.
// RULE17: The trap handler address is used exactly as written.
// RULE18: Seven bits: physical clears them, virtual copies bit 56.
// RULE19: Virtual addresses sign-extend the bit just below the masked bits.
// RULE20: Bare translation, including machine mode, zero-fills the masked bits.
// RULE21: Field value 00 disables; 10 selects seven masked bits.
// RULE22: Field value 11 selects sixteen masked bits; 01 is reserved.
// RULE23: Unmasked accesses pass through with the same latency as masked ones.
// RULE24: The transform precedes translation and validity checks.
module pmat_core
	import pmat_pkg::*;
(
	// Clock and reset.
	input logic REF_CLK,
	input logic RST_N,
	// Register bus.
	input logic PSEL,
	input logic PENABLE,
	input logic PWRITE,
	input logic [`PMAT_AW-1:0] PADDR,
	input logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Data access path toward translation.
	input pmat_acc_t ACC_REQ,
	output pmat_res_t ACC_OUT,
	// Trap delivery.
	input pmat_trap_t TRAP_REQ,
	output pmat_tres_t TRAP_OUT
);

	logic [`PMAT_CFG_W-1:0] pmcfg_r;
	logic [`PMAT_CFG_W-1:0] pmcfg_nxt;
	logic [`PMAT_MODE_W-1:0] mode_r;
	logic [`PMAT_XLEN-1:0] tvec_r;
	logic [`PMAT_XLEN-1:0] trig_r;
	logic [`PMAT_XLEN-1:0] tval_r;
	pmat_ctx_t stat_r;
	pmat_res_t acc_r;
	pmat_tres_t trap_r;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;

	// Works out the effective mode and the setting that applies to it.
	function automatic pmat_ctx_t ctx_of(input pmat_kind_t k, input logic ex,
		input logic [1:0] p, input logic v, input logic [`PMAT_CFG_W-1:0] cfg,
		input logic [`PMAT_MODE_W-1:0] md);
		pmat_ctx_t c;
		logic hyp;
		logic expl;
		logic make_executable_readable;
		logic [1:0] mask_mode_field;
		hyp = (k == AK_HLV) || (k == AK_HLVX);
		expl = (k <= AK_HLV) || ((k == AK_EXT) && !ex); // RULE5 RULE6 RULE10 RULE11
		c.priv = p;
		c.virt = v;
		if (hyp) begin
			c.priv = md[`PMAT_B_SUPERVISOR_PREV_VIRT_PRIVILEGE] ? `PMAT_PRIV_S : `PMAT_PRIV_U; // RULE8
			c.virt = 1'b1;
		end else if (md[`PMAT_B_MODIFY_PRIVILEGE] && (p == `PMAT_PRIV_M)) begin
			c.priv = md[`PMAT_B_MPP +: 2]; // RULE8
			c.virt = md[`PMAT_B_MPV] && (md[`PMAT_B_MPP +: 2] != `PMAT_PRIV_M);
		end
		// Only the privilege context picks the field; the address is not consulted.
		if (c.priv == `PMAT_PRIV_M) begin // RULE2 RULE3 RULE4
			mask_mode_field = cfg[`PMAT_F_M +: 2];
		end else if (c.priv == `PMAT_PRIV_S) begin
			mask_mode_field = c.virt ? cfg[`PMAT_F_VS +: 2] : cfg[`PMAT_F_S +: 2];
		end else if (!c.virt) begin
			mask_mode_field = cfg[`PMAT_F_U +: 2];
		end else if (hyp) begin
			mask_mode_field = (p == `PMAT_PRIV_U) ? cfg[`PMAT_F_HU +: 2] : cfg[`PMAT_F_U +: 2];
		end else begin
			mask_mode_field = cfg[`PMAT_F_VU +: 2];
		end
		c.bare = (c.priv == `PMAT_PRIV_M) ||
			(c.virt ? md[`PMAT_B_VSBARE] : md[`PMAT_B_SBARE]); // RULE20
		make_executable_readable = md[`PMAT_B_MXR] || (c.virt && md[`PMAT_B_VMXR]);
		case (mask_mode_field) // RULE1 RULE21 RULE22
			`PMAT_PMM_SV57: c.cnt = `PMAT_CNT_SV57;
			`PMAT_PMM_SV48: c.cnt = `PMAT_CNT_SV48;
			default: c.cnt = `PMAT_CNT_OFF;
		endcase
		c.use_mask = expl && !make_executable_readable && (c.cnt != `PMAT_CNT_OFF); // RULE7 RULE9
		return c;
	endfunction

	// Replaces the masked bits by zero or by the bit just below them.
	function automatic logic [`PMAT_XLEN-1:0] xform(input logic [`PMAT_XLEN-1:0] a,
		input pmat_ctx_t c);
		logic [`PMAT_XLEN-1:0] hm;
		logic fill;
		hm = (c.cnt == `PMAT_CNT_SV57) ? `PMAT_HI_SV57 : `PMAT_HI_SV48;
		fill = (c.cnt == `PMAT_CNT_SV57) ? a[`PMAT_FILL_SV57] : a[`PMAT_FILL_SV48];
		if (c.bare) begin // RULE20
			fill = 1'b0;
		end
		if (!c.use_mask) begin // RULE23
			hm = `PMAT_RST_ADDR;
		end
		return (a & ~hm) | (fill ? hm : `PMAT_RST_ADDR); // RULE18 RULE19
	endfunction

	// Access path decode.
	pmat_ctx_t ctx_acc;
	pmat_ctx_t ctx_trap;
	logic [`PMAT_XLEN-1:0] last_byte;
	logic [`PMAT_XLEN-1:0] x_addr;
	logic [`PMAT_XLEN-1:0] x_last;
	logic [`PMAT_XLEN-1:0] x_tval;
	logic trig_hit;

	assign ctx_acc = ctx_of(ACC_REQ.kind, ACC_REQ.ext_excl, ACC_REQ.priv, ACC_REQ.virt,
		pmcfg_r, mode_r);
	assign ctx_trap = ctx_of(TRAP_REQ.kind, 1'b0, TRAP_REQ.priv, TRAP_REQ.virt,
		pmcfg_r, mode_r);
	assign x_addr = xform(ACC_REQ.addr, ctx_acc); // RULE24
	assign last_byte = ACC_REQ.addr + {58'h000_0000_0000_0000, ACC_REQ.size_m1};
	assign x_last = xform(last_byte, ctx_acc); // RULE12
	assign trig_hit = mode_r[`PMAT_B_TRIGEN] && (x_addr == trig_r); // RULE16
	assign x_tval = TRAP_REQ.has_addr ? xform(TRAP_REQ.addr, ctx_trap) : `PMAT_RST_ADDR;

	// Register bus decode.
	logic setup;
	logic wr_en;
	logic sel_cfg;
	logic sel_mode;
	logic sel_tvl;
	logic sel_tvh;
	logic sel_tgl;
	logic sel_tgh;
	logic sel_stat;
	logic sel_vall;
	logic sel_valh;
	logic mapped;
	logic [31:0] rd_mux;

	assign setup = PSEL && !PENABLE;
	assign wr_en = PSEL && PENABLE && PWRITE && pready_r && !pslverr_r;
	assign sel_cfg = (PADDR == `PMAT_OFF_PMCFG);
	assign sel_mode = (PADDR == `PMAT_OFF_MODE);
	assign sel_tvl = (PADDR == `PMAT_OFF_TVEC_LO);
	assign sel_tvh = (PADDR == `PMAT_OFF_TVEC_HI);
	assign sel_tgl = (PADDR == `PMAT_OFF_TRIG_LO);
	assign sel_tgh = (PADDR == `PMAT_OFF_TRIG_HI);
	assign sel_stat = (PADDR == `PMAT_OFF_STAT);
	assign sel_vall = (PADDR == `PMAT_OFF_TVAL_LO);
	assign sel_valh = (PADDR == `PMAT_OFF_TVAL_HI);
	assign mapped = sel_cfg | sel_mode | sel_tvl | sel_tvh | sel_tgl | sel_tgh |
		sel_stat | sel_vall | sel_valh;
	assign rd_mux =
		sel_cfg ? {20'h00000, pmcfg_r} :
		sel_mode ? {22'h000000, mode_r} :
		sel_tvl ? tvec_r[31:0] :
		sel_tvh ? tvec_r[63:32] :
		sel_tgl ? trig_r[31:0] :
		sel_tgh ? trig_r[63:32] :
		sel_stat ? {22'h000000, stat_r} :
		sel_vall ? tval_r[31:0] :
		sel_valh ? tval_r[63:32] : 32'h0000_0000;

	// A reserved field value leaves that field as it was.
	genvar g;
	generate
		for (g = 0; g < `PMAT_NFIELD; g++) begin : g_field
			assign pmcfg_nxt[2*g +: 2] =
				(wr_en && sel_cfg && (PWDATA[2*g +: 2] != `PMAT_PMM_RSVD)) ?
				PWDATA[2*g +: 2] : pmcfg_r[2*g +: 2]; // RULE22
		end
	endgenerate

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else begin
			pready_r <= setup;
			pslverr_r <= setup && !mapped;
			prdata_r <= (setup && !PWRITE) ? rd_mux : prdata_r;
		end
	end

	// Software writes to tvec_r and trig_r keep the full value, tagged or not.
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			pmcfg_r <= `PMAT_RST_CFG;
			mode_r <= `PMAT_RST_MODE;
			tvec_r <= `PMAT_RST_ADDR;
			trig_r <= `PMAT_RST_ADDR;
		end else begin
			pmcfg_r <= pmcfg_nxt;
			if (wr_en && sel_mode) begin
				mode_r <= PWDATA[`PMAT_MODE_W-1:0];
			end
			if (wr_en && sel_tvl) begin
				tvec_r[31:0] <= PWDATA; // RULE13 RULE14
			end
			if (wr_en && sel_tvh) begin
				tvec_r[63:32] <= PWDATA;
			end
			if (wr_en && sel_tgl) begin
				trig_r[31:0] <= PWDATA; // RULE13
			end
			if (wr_en && sel_tgh) begin
				trig_r[63:32] <= PWDATA;
			end
		end
	end

	// One register stage for every access, masked or not.
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			acc_r <= '0;
			stat_r <= '0;
		end else begin
			acc_r.valid <= ACC_REQ.valid;
			acc_r.masked <= ACC_REQ.valid && ctx_acc.use_mask;
			acc_r.hit <= ACC_REQ.valid && trig_hit;
			acc_r.addr <= x_addr; // RULE23
			acc_r.last_addr <= x_last;
			if (ACC_REQ.valid) begin
				stat_r <= ctx_acc;
			end
		end
	end

	// The handler address goes out raw; the trap value is masked.
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			trap_r <= '0;
			tval_r <= `PMAT_RST_ADDR;
		end else begin
			trap_r.valid <= TRAP_REQ.valid;
			trap_r.handler <= tvec_r; // RULE17
			trap_r.tval <= x_tval; // RULE15
			if (TRAP_REQ.valid) begin
				tval_r <= x_tval;
			end
		end
	end

	assign PRDATA = prdata_r;
	assign PREADY = pready_r;
	assign PSLVERR = pslverr_r;
	assign ACC_OUT = acc_r;
	assign TRAP_OUT = trap_r;

	// Checks.
	sequence s_setup;
		PSEL && !PENABLE;
	endsequence

	sequence s_ready_once;
		PREADY ##1 !PREADY;
	endsequence

	property p_apb_answer;
		@(posedge REF_CLK) disable iff (!RST_N) s_setup |=> s_ready_once;
	endproperty
	a_apb_answer: assert property (p_apb_answer) else $error("ready not one cycle after setup");

	property p_pass;
		@(posedge REF_CLK) disable iff (!RST_N)
		ACC_REQ.valid && !ctx_acc.use_mask |=> ACC_OUT.addr == $past(ACC_REQ.addr);
	endproperty
	a_pass: assert property (p_pass) else $error("exempt address altered"); // RULE23

	property p_fence;
		@(posedge REF_CLK) disable iff (!RST_N)
		ACC_REQ.valid && ACC_REQ.kind == AK_FENCE_INV |=> !ACC_OUT.masked;
	endproperty
	a_fence: assert property (p_fence) else $error("fence operand masked"); // RULE7

	property p_implicit;
		@(posedge REF_CLK) disable iff (!RST_N)
		ACC_REQ.valid && (ACC_REQ.kind inside {AK_IMPLICIT, AK_DEVICE, AK_FETCH})
		|=> ACC_OUT.valid && !ACC_OUT.masked && ACC_OUT.addr == $past(ACC_REQ.addr);
	endproperty
	a_implicit: assert property (p_implicit) else $error("implicit access masked"); // RULE11

	property p_zero7;
		@(posedge REF_CLK) disable iff (!RST_N)
		ACC_REQ.valid && ctx_acc.use_mask && ctx_acc.bare && ctx_acc.cnt == `PMAT_CNT_SV57
		|=> ACC_OUT.addr[63:57] == 7'h00 && ACC_OUT.addr[56:0] == $past(ACC_REQ.addr[56:0]);
	endproperty
	a_zero7: assert property (p_zero7) else $error("physical 7-bit fill wrong"); // RULE18

	property p_sext16;
		@(posedge REF_CLK) disable iff (!RST_N)
		ACC_REQ.valid && ctx_acc.use_mask && !ctx_acc.bare && ctx_acc.cnt == `PMAT_CNT_SV48
		|=> ACC_OUT.addr[63:48] == {16{$past(ACC_REQ.addr[47])}};
	endproperty
	a_sext16: assert property (p_sext16) else $error("virtual 16-bit fill wrong"); // RULE19

	property p_handler;
		@(posedge REF_CLK) disable iff (!RST_N)
		TRAP_REQ.valid |=> TRAP_OUT.valid && TRAP_OUT.handler == $past(tvec_r);
	endproperty
	a_handler: assert property (p_handler) else $error("handler address changed"); // RULE17

	property p_reserved;
		@(posedge REF_CLK) disable iff (!RST_N)
		wr_en && sel_cfg && PWDATA[1:0] == `PMAT_PMM_RSVD
		|=> pmcfg_r[1:0] == $past(pmcfg_r[1:0]);
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved encoding stored"); // RULE22

	property p_mxr;
		@(posedge REF_CLK) disable iff (!RST_N)
		ACC_REQ.valid && mode_r[`PMAT_B_MXR] |=> !ACC_OUT.masked;
	endproperty
	a_mxr: assert property (p_mxr) else $error("masked while exec-readable set"); // RULE9

	sequence s_acc_taken;
		ACC_REQ.valid;
	endsequence

	property p_valid;
		@(posedge REF_CLK) disable iff (!RST_N) s_acc_taken |=> ACC_OUT.valid;
	endproperty
	a_valid: assert property (p_valid) else $error("access answer missing"); // RULE23

	property p_idle;
		@(posedge REF_CLK) disable iff (!RST_N)
		!ACC_REQ.valid |=> !ACC_OUT.valid && !ACC_OUT.masked && !ACC_OUT.hit;
	endproperty
	a_idle: assert property (p_idle) else $error("answer without request"); // RULE23

	property p_hit;
		@(posedge REF_CLK) disable iff (!RST_N)
		ACC_OUT.hit |-> ACC_OUT.addr == $past(trig_r) && $past(mode_r[`PMAT_B_TRIGEN]);
	endproperty
	a_hit: assert property (p_hit) else $error("trigger hit on other address"); // RULE16

	property p_sext7;
		@(posedge REF_CLK) disable iff (!RST_N)
		ACC_REQ.valid && ctx_acc.use_mask && !ctx_acc.bare && ctx_acc.cnt == `PMAT_CNT_SV57
		|=> ACC_OUT.addr[63:57] == {7{$past(ACC_REQ.addr[56])}};
	endproperty
	a_sext7: assert property (p_sext7) else $error("virtual 7-bit fill wrong"); // RULE18

	property p_bare;
		@(posedge REF_CLK) disable iff (!RST_N)
		ACC_REQ.valid && ctx_acc.use_mask && ctx_acc.bare |=> !ACC_OUT.addr[`PMAT_XLEN-1];
	endproperty
	a_bare: assert property (p_bare) else $error("physical top bit not cleared"); // RULE20

	property p_tval16;
		@(posedge REF_CLK) disable iff (!RST_N)
		TRAP_REQ.valid && TRAP_REQ.has_addr && ctx_trap.use_mask && !ctx_trap.bare &&
		ctx_trap.cnt == `PMAT_CNT_SV48
		|=> TRAP_OUT.tval[63:48] == {16{$past(TRAP_REQ.addr[47])}};
	endproperty
	a_tval16: assert property (p_tval16) else $error("trap value fill wrong"); // RULE15

endmodule

// [dv/pmat_lsu_model.sv]
`include "pmat_defs.svh"

module pmat_lsu_model
	import pmat_pkg::*;
(
	// Clock.
	input wire logic clk,
	// Request toward the block.
	output pmat_acc_t req
);
	timeunit 1ns;
	timeprecision 1ps;

	initial req = '0;

	// Holds one request for one cycle, then drops valid and scrambles the address.
	task automatic send(input pmat_kind_t k, input logic [1:0] p, input logic x,
		input logic [5:0] sz, input logic [63:0] a);
		@(posedge clk);
		req <= '{valid: 1'b1, kind: k, ext_excl: x, priv: p, virt: 1'b0, size_m1: sz, addr: a};
		@(posedge clk);
		req <= '{valid: 1'b0, kind: AK_FETCH, ext_excl: 1'b0, priv: 2'h0, virt: 1'b0,
			size_m1: 6'h00, addr: ~a};
	endtask
endmodule

// [dv/tb_pointer_mask_address_transform.sv]
`include "pmat_defs.svh"

module tb_pointer_mask_address_transform
	import pmat_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [1:0] PU = `PMAT_PRIV_U;
	localparam logic [1:0] PS = `PMAT_PRIV_S;
	localparam logic [1:0] PM = `PMAT_PRIV_M;
	localparam logic [63:0] A = 64'h5a5a_8123_4567_89ab;
	localparam logic [63:0] A7 = 64'hab00_0000_1234_5678;
	localparam logic [63:0] M2 = 64'h1234_7fff_ffff_fffc;

	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	pmat_acc_t acc_req;
	pmat_res_t acc_out;
	pmat_trap_t trap_req = '0;
	pmat_tres_t trap_out;
	int fail_count = 0;
	int tests_run = 0;
	int cycles = 0;
	logic [31:0] rd;
	logic er;

	pmat_core i_pmat_core (.REF_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .ACC_REQ(acc_req), .ACC_OUT(acc_out), .TRAP_REQ(trap_req),
		.TRAP_OUT(trap_out));

	pmat_lsu_model i_pmat_lsu_model (.clk(clk), .req(acc_req));

	initial begin
		forever #10 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fail_count++;
			final_report();
		end
	end

	task automatic final_report();
		$display("checks %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask

	function automatic logic [63:0] xf(input logic [63:0] a, input int c, input logic bare);
		logic [63:0] lo;
		lo = (64'h1 << (64 - c)) - 64'h1;
		if (c == 0) return a;
		if (bare || !a[63 - c]) return a & lo;
		return a | ~lo;
	endfunction

	// One APB transfer; read data and error are taken at the edge that sees PREADY.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(n, {32'h0, e}, {32'h0, rd});
	endtask

	task automatic acc(input string n, input pmat_kind_t k, input logic [1:0] p,
		input logic x, input logic [63:0] a, input logic [63:0] e);
		i_pmat_lsu_model.send(k, p, x, 6'h00, a);
		#1;
		chk(n, e, acc_out.addr);
		chk({n, " valid"}, 64'h1, {63'h0, acc_out.valid});
		chk({n, " masked"}, {63'h0, e != a}, {63'h0, acc_out.masked});
	endtask

	task automatic t_reset();
		rdc("cfg reset", `PMAT_OFF_PMCFG, 32'h0);
		rdc("mode reset", `PMAT_OFF_MODE, 32'h180);
		apb(1'b1, 8'h24, 32'hffff_ffff);
		chk("unmapped error", 64'h1, {63'h0, er});
		acc("off load", AK_LOAD, PU, 1'b0, A, A);
	endtask

	task automatic t_modes();
		wr(`PMAT_OFF_PMCFG, 32'h3b);
		wr(`PMAT_OFF_MODE, 32'h100);
		acc("u sixteen", AK_LOAD, PU, 1'b0, A, xf(A, 16, 1'b0));
		acc("s seven", AK_STORE, PS, 1'b0, A7, xf(A7, 7, 1'b0));
		acc("m zero", AK_LOAD, PM, 1'b0, A, xf(A, 16, 1'b1));
		acc("top bit", AK_LOAD, PU, 1'b0, A ^ 64'h8000_0000_0000_0000, xf(A, 16, 1'b0));
		wr(`PMAT_OFF_MODE, 32'h180);
		acc("u bare", AK_LOAD, PU, 1'b0, A, xf(A, 16, 1'b1));
		acc("s bare seven", AK_STORE, PS, 1'b0, A7, xf(A7, 7, 1'b1));
		wr(`PMAT_OFF_PMCFG, 32'h19);
		rdc("cfg keep", `PMAT_OFF_PMCFG, 32'h3b);
	endtask

	task automatic t_kinds();
		logic [63:0] e;
		wr(`PMAT_OFF_MODE, 32'h000);
		for (int k = 0; k < 14; k++) begin
			// The HU field is still off here, so guest loads issued from user mode pass unmasked.
			e = (k < AK_HLV || k == AK_EXT) ? xf(A, 16, 1'b0) : A;
			acc("kind", pmat_kind_t'(k), PU, 1'b0, A, e);
		end
		acc("excluded ext", AK_EXT, PU, 1'b1, A, A);
		wr(`PMAT_OFF_PMCFG, 32'h0000_0c3b);
		acc("guest load", AK_HLV, PU, 1'b0, A, xf(A, 16, 1'b0));
	endtask

	task automatic t_ctrl();
		wr(`PMAT_OFF_MODE, 32'h001);
		acc("modify_privilege user", AK_LOAD, PM, 1'b0, A, xf(A, 16, 1'b0));
		wr(`PMAT_OFF_MODE, 32'h003);
		acc("modify_privilege super", AK_LOAD, PM, 1'b0, A7, xf(A7, 7, 1'b0));
		wr(`PMAT_OFF_MODE, 32'h020);
		acc("mxr", AK_LOAD, PU, 1'b0, A, A);
		wr(`PMAT_OFF_MODE, 32'h1a0);
		acc("mxr bare", AK_LOAD, PU, 1'b0, A, A);
	endtask

	task automatic t_mis();
		wr(`PMAT_OFF_MODE, 32'h000);
		i_pmat_lsu_model.send(AK_LOAD, PU, 1'b0, 6'h07, M2);
		#1;
		chk("first byte", xf(M2, 16, 1'b0), acc_out.addr);
		chk("last byte", xf(M2 + 64'h7, 16, 1'b0), acc_out.last_addr);
		rdc("status", `PMAT_OFF_STAT, 32'h0000_0280);
	endtask

	task automatic t_trap();
		logic [63:0] t;
		t = xf(A, 16, 1'b0);
		wr(`PMAT_OFF_MODE, 32'h200);
		wr(`PMAT_OFF_TRIG_LO, t[31:0]);
		wr(`PMAT_OFF_TRIG_HI, t[63:32]);
		wr(`PMAT_OFF_TVEC_LO, 32'h0000_1000);
		wr(`PMAT_OFF_TVEC_HI, 32'hdead_0000);
		rdc("tvec raw", `PMAT_OFF_TVEC_HI, 32'hdead_0000);
		i_pmat_lsu_model.send(AK_LOAD, PU, 1'b0, 6'h00, A);
		#1;
		chk("trigger hit", 64'h1, {63'h0, acc_out.hit});
		@(posedge clk);
		trap_req <= '{valid: 1'b1, has_addr: 1'b1, kind: AK_LOAD, priv: PU, virt: 1'b0, addr: A};
		@(posedge clk);
		trap_req.valid <= 1'b0;
		trap_req.addr <= ~A;
		#1;
		chk("trap valid", 64'h1, {63'h0, trap_out.valid});
		chk("handler", 64'hdead_0000_0000_1000, trap_out.handler);
		chk("trap value", t, trap_out.tval);
		rdc("trap value reg", `PMAT_OFF_TVAL_HI, t[63:32]);
	endtask

	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_modes();
		t_kinds();
		t_ctrl();
		t_mis();
		t_trap();
		final_report();
	end
endmodule
